// *** design/fpru_fabric.sv ***
/*
 * fabric end of the rounding unit: picks carry, constant, pattern and
 * mask per mode, then truncates and corrects the slice result.
 * assumes the slice answers one clock after each request.
 */
// Notes on behaviour
// - constant ones plus one give fraction bits
// - slice adds constant and carry to data
// - drop all bits below the point
// - constant and carry may change each cycle
// - towards infinity: carry is inverted sign
// - towards zero: carry is the sign
// - select code 110 gives built-in sign bar
// - accumulate: constant first, sign two beats before last
// - random rounding: carry from seeded lfsr
// - static odd: carry 0, set units
// - static even: carry 1, clear units
// - dynamic: zero pattern, fraction-only mask
// - mask is complement of constant shifted
// - dynamic even: carry 1, clear on match
// - dynamic odd: carry 0, set on inverse
// - match zeros, inverse match ones
// - correction bit added to the result before truncation
// - masked compare against pattern, both senses
module fpru_fabric #(
    parameter int P_W = fpru_pkg::DEF_P_W,
    parameter int A_W = fpru_pkg::DEF_A_W,
    parameter int B_W = fpru_pkg::DEF_B_W
) (
    // clock and reset
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST_N,
    // request from the user
    input  wire logic                       I_VALID,
    input  wire fpru_pkg::fpru_mode_t       I_MODE,
    input  wire logic [A_W-1:0]             I_A,
    input  wire logic [B_W-1:0]             I_B,
    input  wire logic [P_W-1:0]             I_ROUND_CONST,
    // accumulate framing
    input  wire logic                       I_ACC_EN,
    input  wire logic                       I_ACC_FIRST,
    input  wire logic                       I_ACC_LAST,
    // random seed
    input  wire logic                       I_SEED_LOAD,
    input  wire logic [fpru_pkg::LFSR_W-1:0] I_SEED,
    // rounded answer
    output logic                            O_VALID,
    output logic [P_W-1:0]                  O_RESULT,
    // link to the slice
    fpru_if.fabric                          lnk
);
    import fpru_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (P_W < 4 || $bits(lnk.result) != P_W) begin : g_bad_w
        $error("result width unusable or differs from link");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // fraction bits from constant
    function automatic logic [P_W-1:0] frac_of(input logic [P_W-1:0] c);
        frac_of = {c[P_W-2:0], 1'b1};
    endfunction

    // lowest zero above the fraction run is the units place
    function automatic logic [P_W-1:0] units_of(input logic [P_W-1:0] c);
        logic [P_W-1:0] f;
        f = frac_of(c);
        units_of = f ^ {f[P_W-2:0], 1'b1};
    endfunction

    // ------------------------------------------------------------
    // request stage
    // ------------------------------------------------------------
    logic                 vld_ff, nxt_vld;
    logic [A_W-1:0]       a_ff, nxt_a;
    logic [B_W-1:0]       b_ff, nxt_b;
    logic [P_W-1:0]       c_ff, nxt_c;
    logic                 cin_ff, nxt_cin;
    logic [CSEL_W-1:0]    csel_ff, nxt_csel;
    logic [OPS_W-1:0]     ops_ff, nxt_ops;
    logic                 msh_ff, nxt_msh;
    logic [P_W-1:0]       pat_ff, nxt_pat;
    logic [P_W-1:0]       msk_ff, nxt_msk;
    logic                 out_ff, nxt_out;
    fpru_mode_t           mode_ff, nxt_mode;
    logic [LFSR_W-1:0]    lfsr_ff, nxt_lfsr;

    logic                 round_now;
    logic                 sign;
    logic [P_W-1:0]       frac;
    logic [P_W-1:0]       units;

    always_comb begin
        round_now = !I_ACC_EN || I_ACC_LAST;
        frac      = frac_of(I_ROUND_CONST);
        units     = units_of(I_ROUND_CONST);
        // sign of the running sum on the last beat
        if (I_ACC_EN) begin
            sign = lnk.result[P_W-1];
        end else begin
            sign = I_A[A_W-1] ^ I_B[B_W-1];
        end
        nxt_vld  = I_VALID;
        nxt_a    = I_A;
        nxt_b    = I_B;
        // constant follows the user each cycle
        nxt_c    = I_ROUND_CONST;
        nxt_mode = I_MODE;
        nxt_out  = I_VALID && round_now;
        nxt_csel = CSEL_CARRY_PIN;
        nxt_msh  = 1'b0;
        nxt_pat  = '0;
        nxt_msk  = ~(frac | units);
        nxt_cin  = 1'b0;
        nxt_ops  = '0;
        nxt_ops[OPS_ADD_CONST] = (I_MODE != RND_TRUNC) &&
                                 (!I_ACC_EN || I_ACC_FIRST);
        nxt_ops[OPS_ACCUM]     = I_ACC_EN && !I_ACC_FIRST;
        nxt_lfsr = lfsr_ff;
        case (I_MODE)
            RND_TRUNC: begin
                nxt_cin = 1'b0;
            end
            RND_SYM_INF: begin
                nxt_cin = !sign;
            end
            // let the slice pick sign bar
            RND_SYM_INF_SLICE: begin
                if (round_now) begin
                    nxt_csel = CSEL_SIGN_BAR;
                end
            end
            RND_SYM_ZERO: begin
                nxt_cin = sign;
            end
            RND_RANDOM: begin
                nxt_cin = lfsr_ff[0];
                if (I_VALID && round_now) begin
                    nxt_lfsr = lfsr_ff[0] ?
                               ((lfsr_ff >> 1) ^ LFSR_TAPS) :
                               (lfsr_ff >> 1);
                end
            end
            RND_CONV_ODD_LSB: begin
                nxt_cin = 1'b0;
                nxt_pat = frac;
            end
            RND_CONV_EVEN_LSB: begin
                nxt_cin = 1'b1;
                nxt_pat = units;
            end
            RND_DYN_EVEN: begin
                nxt_cin = 1'b1;
                nxt_msh = 1'b1;
            end
            RND_DYN_ODD: begin
                nxt_cin = 1'b0;
                nxt_msh = 1'b1;
            end
            RND_CC_EVEN: begin
                nxt_pat = frac | units;
            end
            RND_CC_ODD: begin
                nxt_pat = frac;
            end
            default: begin
                nxt_cin = 1'b0;
            end
        endcase
        // a carry on every beat would pile up in the accumulator
        if (!round_now) begin
            nxt_cin = 1'b0;
        end
        if (I_SEED_LOAD) begin
            nxt_lfsr = (I_SEED == '0) ? LFSR_RST_SEED : I_SEED;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            vld_ff  <= RST_BIT;
            a_ff    <= '0;
            b_ff    <= '0;
            c_ff    <= '0;
            cin_ff  <= RST_BIT;
            csel_ff <= RST_CSEL;
            ops_ff  <= RST_OPS;
            msh_ff  <= RST_BIT;
            pat_ff  <= '0;
            msk_ff  <= '0;
            out_ff  <= RST_BIT;
            mode_ff <= RND_TRUNC;
            lfsr_ff <= LFSR_RST_SEED;
        end else begin
            vld_ff  <= nxt_vld;
            a_ff    <= nxt_a;
            b_ff    <= nxt_b;
            c_ff    <= nxt_c;
            cin_ff  <= nxt_cin;
            csel_ff <= nxt_csel;
            ops_ff  <= nxt_ops;
            msh_ff  <= nxt_msh;
            pat_ff  <= nxt_pat;
            msk_ff  <= nxt_msk;
            out_ff  <= nxt_out;
            mode_ff <= nxt_mode;
            lfsr_ff <= nxt_lfsr;
        end
    end

    assign lnk.req_valid           = vld_ff;
    assign lnk.op_a                = a_ff;
    assign lnk.op_b                = b_ff;
    assign lnk.round_const         = c_ff;
    assign lnk.carry_input         = cin_ff;
    assign lnk.carry_source_select = csel_ff;
    assign lnk.operation_select    = ops_ff;
    assign lnk.mask_single_shift   = msh_ff;
    assign lnk.pattern             = pat_ff;
    assign lnk.mask                = msk_ff;

    // ------------------------------------------------------------
    // answer stage: tags wait one cycle beside the slice
    // ------------------------------------------------------------
    logic                 t_out_ff, nxt_t_out;
    fpru_mode_t           t_mode_ff, nxt_t_mode;
    logic [P_W-1:0]       t_c_ff, nxt_t_c;
    logic                 o_vld_ff, nxt_o_vld;
    logic [P_W-1:0]       o_res_ff, nxt_o_res;
    logic [P_W-1:0]       t_units;
    logic [P_W-1:0]       sum;

    always_comb begin
        nxt_t_out  = vld_ff && out_ff;
        nxt_t_mode = mode_ff;
        nxt_t_c    = c_ff;
        t_units    = units_of(t_c_ff);
        sum        = lnk.result;
        if (t_mode_ff == RND_CC_EVEN || t_mode_ff == RND_CC_ODD) begin
            sum = lnk.result + {{(P_W-1){1'b0}}, lnk.match_flag};
        end
        sum = sum & ~frac_of(t_c_ff);
        case (t_mode_ff)
            RND_CONV_ODD_LSB: begin
                if (lnk.match_flag) begin
                    sum = sum | t_units;
                end
            end
            RND_CONV_EVEN_LSB: begin
                if (lnk.match_flag) begin
                    sum = sum & ~t_units;
                end
            end
            RND_DYN_EVEN: begin
                if (lnk.match_flag) begin
                    sum = sum & ~t_units;
                end
            end
            RND_DYN_ODD: begin
                if (lnk.inverse_match_flag) begin
                    sum = sum | t_units;
                end
            end
            default: begin
                sum = sum;
            end
        endcase
        nxt_o_vld = t_out_ff && lnk.result_valid;
        nxt_o_res = nxt_o_vld ? sum : o_res_ff;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            t_out_ff  <= RST_BIT;
            t_mode_ff <= RND_TRUNC;
            t_c_ff    <= '0;
            o_vld_ff  <= RST_BIT;
            o_res_ff  <= '0;
        end else begin
            t_out_ff  <= nxt_t_out;
            t_mode_ff <= nxt_t_mode;
            t_c_ff    <= nxt_t_c;
            o_vld_ff  <= nxt_o_vld;
            o_res_ff  <= nxt_o_res;
        end
    end

    assign O_VALID  = o_vld_ff;
    assign O_RESULT = o_res_ff;

endmodule

// *** design/fpru_if.sv ***
/*
 * link between the rounding slice and the fabric logic around it.
 * assumes one clock shared by both ends; no clocking block.
 */
interface fpru_if #(
    parameter int P_W = fpru_pkg::DEF_P_W,
    parameter int A_W = fpru_pkg::DEF_A_W,
    parameter int B_W = fpru_pkg::DEF_B_W
) ();
    // ------------------------------------------------------------
    // request, fabric to slice
    // ------------------------------------------------------------
    logic                      req_valid;
    logic [A_W-1:0]            op_a;
    logic [B_W-1:0]            op_b;
    logic [P_W-1:0]            round_const;
    logic                      carry_input;
    logic [fpru_pkg::CSEL_W-1:0] carry_source_select;
    logic [fpru_pkg::OPS_W-1:0]  operation_select;
    logic                      mask_single_shift;
    logic [P_W-1:0]            pattern;
    logic [P_W-1:0]            mask;
    // ------------------------------------------------------------
    // answer, slice to fabric
    // ------------------------------------------------------------
    logic                      result_valid;
    logic [P_W-1:0]            result;
    logic                      match_flag;
    logic                      inverse_match_flag;

    modport slice (
        input  req_valid, op_a, op_b, round_const, carry_input,
               carry_source_select, operation_select,
               mask_single_shift, pattern, mask,
        output result_valid, result, match_flag, inverse_match_flag
    );
    modport fabric (
        output req_valid, op_a, op_b, round_const, carry_input,
               carry_source_select, operation_select,
               mask_single_shift, pattern, mask,
        input  result_valid, result, match_flag, inverse_match_flag
    );
endinterface

// *** design/fpru_pkg.sv ***
/*
 * shared constants and types of the fixed-point rounding unit: widths,
 * carry source codes, operation select bits, lfsr setup and modes.
 * assumes both ends are compiled after this package.
 */
package fpru_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DEF_P_W = 48;
    localparam int DEF_A_W = 25;
    localparam int DEF_B_W = 18;
    localparam int CSEL_W  = 3;
    localparam int OPS_W   = 2;
    localparam int LFSR_W  = 16;

    // ------------------------------------------------------------
    // carry source codes and operation select bit positions
    // ------------------------------------------------------------
    localparam logic [CSEL_W-1:0] CSEL_CARRY_PIN = 3'h0;
    localparam logic [CSEL_W-1:0] CSEL_SIGN_BAR  = 3'h6;
    localparam int OPS_ADD_CONST = 0;
    localparam int OPS_ACCUM     = 1;

    // ------------------------------------------------------------
    // reset values and lfsr taps
    // ------------------------------------------------------------
    localparam logic              RST_BIT  = 1'b0;
    localparam logic [CSEL_W-1:0] RST_CSEL = 3'h0;
    localparam logic [OPS_W-1:0]  RST_OPS  = 2'h0;
    localparam logic [LFSR_W-1:0] LFSR_RST_SEED = 16'hace1;
    localparam logic [LFSR_W-1:0] LFSR_TAPS     = 16'hb400;

    // ------------------------------------------------------------
    // rounding modes of the fabric end
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RND_TRUNC,
        RND_SYM_INF,
        RND_SYM_INF_SLICE,
        RND_SYM_ZERO,
        RND_RANDOM,
        RND_CONV_EVEN_LSB,
        RND_CONV_ODD_LSB,
        RND_DYN_EVEN,
        RND_DYN_ODD,
        RND_CC_EVEN,
        RND_CC_ODD
    } fpru_mode_t;

endpackage

// *** design/fpru_slice.sv ***
/*
 * multiply-add slice with rounding constant, carry input and masked
 * pattern detector; result and both flags registered together.
 * assumes its requests come from logic on the same clock.
 */
module fpru_slice #(
    parameter int P_W = fpru_pkg::DEF_P_W,
    parameter int A_W = fpru_pkg::DEF_A_W,
    parameter int B_W = fpru_pkg::DEF_B_W
) (
    // clock and reset
    input  wire logic I_CLK,
    input  wire logic I_RST_N,
    // link to the fabric
    fpru_if.slice     lnk
);
    import fpru_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (A_W + B_W >= P_W) begin : g_bad_w
        $error("product must be narrower than the result");
    end
    if ($bits(lnk.result) != P_W) begin : g_bad_if
        $error("link width differs from slice width");
    end

    localparam int M_W = A_W + B_W;

    logic signed [M_W-1:0] prod;
    logic [P_W-1:0]        prod_ext;
    logic [P_W-1:0]        z_term;
    logic [P_W-1:0]        c_term;
    logic [P_W-1:0]        det_mask;
    logic                  carry;

    logic [P_W-1:0]        p_ff;
    logic                  match_ff;
    logic                  inv_ff;
    logic                  vld_ff;
    logic [P_W-1:0]        nxt_p;
    logic                  nxt_match;
    logic                  nxt_inv;
    logic                  nxt_vld;

    // ------------------------------------------------------------
    // adder and detector
    // ------------------------------------------------------------
    always_comb begin
        prod     = $signed(lnk.op_a) * $signed(lnk.op_b);
        prod_ext = {{(P_W-M_W){prod[M_W-1]}}, prod};
        if (lnk.carry_source_select == CSEL_SIGN_BAR) begin
            carry = ~prod[M_W-1];
        end else begin
            carry = lnk.carry_input;
        end
        z_term = lnk.operation_select[OPS_ACCUM] ? p_ff : '0;
        c_term = lnk.operation_select[OPS_ADD_CONST] ?
                 lnk.round_const : '0;
        if (lnk.mask_single_shift) begin
            // complement first, so the lowest fraction bit stays examined
            det_mask = {~lnk.round_const[P_W-2:0], 1'b0};
        end else begin
            det_mask = lnk.mask;
        end
        nxt_p = prod_ext + z_term + c_term + {{(P_W-1){1'b0}}, carry};
        nxt_match = &((nxt_p ~^ lnk.pattern) | det_mask);
        nxt_inv   = &((nxt_p ^ lnk.pattern) | det_mask);
        nxt_vld   = lnk.req_valid;
        // idle cycles keep the last word so the fabric may look again
        if (!lnk.req_valid) begin
            nxt_p     = p_ff;
            nxt_match = match_ff;
            nxt_inv   = inv_ff;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // flags aligned with sum
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            p_ff     <= '0;
            match_ff <= RST_BIT;
            inv_ff   <= RST_BIT;
            vld_ff   <= RST_BIT;
        end else begin
            p_ff     <= nxt_p;
            match_ff <= nxt_match;
            inv_ff   <= nxt_inv;
            vld_ff   <= nxt_vld;
        end
    end

    assign lnk.result             = p_ff;
    assign lnk.match_flag         = match_ff;
    assign lnk.inverse_match_flag = inv_ff;
    assign lnk.result_valid       = vld_ff;

endmodule

// *** verification/fixed_point_rounding_unit_bench.sv ***
/*
 * bench of the rounding unit: both ends joined, user side driven and
 * answers checked against a rounding model. assumes the package only.
 */
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("wrong value at %0t: %h not %h", $time, got, exp); \
    end \
end
module fixed_point_rounding_unit_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import fpru_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                I_CLK = 1'h0;
    logic                I_RST_N = 1'h0;
    logic                I_VALID = 1'h0;
    fpru_mode_t          I_MODE = RND_TRUNC;
    logic [DEF_A_W-1:0]  I_A = '0;
    logic [DEF_B_W-1:0]  I_B = '0;
    logic [DEF_P_W-1:0]  I_ROUND_CONST = '0;
    logic [2:0]          acc = 3'h0;
    logic                I_SEED_LOAD = 1'h0;
    logic [LFSR_W-1:0]   I_SEED = '0;
    logic                O_VALID;
    logic [DEF_P_W-1:0]  O_RESULT;
    logic [DEF_P_W-1:0]  exp_q[$];
    logic [DEF_P_W-1:0]  got_e;
    logic [LFSR_W-1:0]   lfsr_m;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 87100;
    int prods[6] = '{40, -40, 56, -24, -56, 24};

    fpru_if lnk ();
    fpru_slice i_fpru_slice (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .lnk(lnk));
    fpru_fabric i_fpru_fabric (
        .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_VALID(I_VALID),
        .I_MODE(I_MODE), .I_A(I_A), .I_B(I_B),
        .I_ROUND_CONST(I_ROUND_CONST), .I_ACC_EN(acc[2]),
        .I_ACC_FIRST(acc[1]), .I_ACC_LAST(acc[0]),
        .I_SEED_LOAD(I_SEED_LOAD), .I_SEED(I_SEED),
        .O_VALID(O_VALID), .O_RESULT(O_RESULT), .lnk(lnk));
    fpru_props #(.P_W(DEF_P_W), .A_W(DEF_A_W), .B_W(DEF_B_W)) i_fpru_props (
        .I_CLK(I_CLK), .I_RST_N(I_RST_N), .req_valid(lnk.req_valid),
        .op_a(lnk.op_a), .op_b(lnk.op_b), .round_const(lnk.round_const),
        .carry_input(lnk.carry_input),
        .carry_source_select(lnk.carry_source_select),
        .operation_select(lnk.operation_select),
        .mask_single_shift(lnk.mask_single_shift),
        .pattern(lnk.pattern), .mask(lnk.mask),
        .result_valid(lnk.result_valid), .result(lnk.result),
        .match_flag(lnk.match_flag),
        .inverse_match_flag(lnk.inverse_match_flag));

    initial begin
        forever #10 I_CLK = ~I_CLK;
    end
    // ------------------------------------------------------------
    // rounding model; alt is the other legal answer of random mode
    // ------------------------------------------------------------
    function automatic void model(input fpru_mode_t m,
            input logic [DEF_P_W-1:0] p, input logic [DEF_P_W-1:0] c,
            input logic s, output logic [DEF_P_W-1:0] e,
            output logic [DEF_P_W-1:0] alt);
        logic [DEF_P_W-1:0] f, u, sum, t;
        f = {c[DEF_P_W-2:0], 1'h1};
        u = f + 1'h1;
        sum = p + ((m == RND_TRUNC) ? '0 : c);
        case (m)
            RND_SYM_INF, RND_SYM_INF_SLICE: sum = sum + DEF_P_W'(!s);
            RND_SYM_ZERO: sum = sum + DEF_P_W'(s);
            RND_CONV_EVEN_LSB, RND_DYN_EVEN: sum = sum + 1'h1;
            default: ;
        endcase
        t = sum & ~f;
        case (m)
            RND_CONV_EVEN_LSB, RND_DYN_EVEN: t = ((sum & f) == '0) ? t & ~u : t;
            RND_CONV_ODD_LSB, RND_DYN_ODD: t = ((sum & f) == f) ? t | u : t;
            RND_CC_EVEN: t = (sum + ((sum & (f | u)) == (f | u))) & ~f;
            RND_CC_ODD: t = (sum + ((sum & (f | u)) == f)) & ~f;
            default: ;
        endcase
        e = t;
        alt = (m == RND_RANDOM) ? (sum + 1'h1) & ~f : t;
    endfunction

    task automatic drive(input fpru_mode_t m, input logic [DEF_A_W-1:0] a,
            input logic [DEF_B_W-1:0] b, input logic [DEF_P_W-1:0] c,
            input logic [2:0] fr);
        @(negedge I_CLK);
        I_VALID = 1'h1;
        I_MODE = m;
        I_A = a;
        I_B = b;
        I_ROUND_CONST = c;
        acc = fr;
    endtask

    task automatic one(input fpru_mode_t m, input logic [DEF_A_W-1:0] a,
            input logic [DEF_B_W-1:0] b, input logic [DEF_P_W-1:0] c,
            input logic [2:0] fr);
        logic [DEF_P_W-1:0] p, e, x;
        p = $signed(a) * $signed(b);
        // sign taken as the fabric does, or from the product as the slice does in RND_SYM_INF_SLICE
        model(m, p, c, (m == RND_SYM_INF_SLICE) ? p[DEF_P_W-1] :
              a[DEF_A_W-1] ^ b[DEF_B_W-1], e, x);
        // carry is the low lfsr bit
        if (m == RND_RANDOM) begin
            e = lfsr_m[0] ? x : e;
            lfsr_m = lfsr_m[0] ? (lfsr_m >> 1) ^ LFSR_TAPS : lfsr_m >> 1;
        end
        exp_q.push_back(e);
        drive(m, a, b, c, fr);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchers
    // ------------------------------------------------------------
    always @(posedge I_CLK) begin
        cycles++;
        if (lnk.req_valid === 1'h1 && lnk.mask_single_shift === 1'h1) begin
            `CHK(lnk.pattern, 48'h0)
        end
        if (O_VALID === 1'h1 && exp_q.size() > 0) begin
            got_e = exp_q.pop_front();
            `CHK(O_RESULT, got_e)
        end else if (O_VALID === 1'h1) begin
            `CHK(O_VALID, 1'h0)
        end
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        logic [DEF_P_W-1:0] e, x, s1;
        repeat (2) @(negedge I_CLK);
        I_RST_N = 1'h1;
        @(negedge I_CLK);
        I_SEED = LFSR_W'($random(seed));
        lfsr_m = (I_SEED == '0) ? LFSR_RST_SEED : I_SEED;
        I_SEED_LOAD = 1'h1;
        @(negedge I_CLK);
        I_SEED_LOAD = 1'h0;
        for (int i = 0; i < 11; i++) begin
            for (int j = 0; j < 6; j++) begin
                one(fpru_mode_t'(i), DEF_A_W'(prods[j]), 18'h1, 48'h7, 3'h0);
            end
        end
        one(RND_DYN_ODD, 25'h28, 18'h1, 48'h7, 3'h7);
        $display("test directed done");
        // point and carry move every cycle
        for (int i = 0; i < 200; i++) begin
            one(fpru_mode_t'($unsigned($random(seed)) % 11),
                DEF_A_W'($random(seed)), DEF_B_W'($random(seed)),
                (48'h1 << ($unsigned($random(seed)) % 40)) - 48'h1, 3'h0);
        end
        $display("test random done");
        // constant on first beat, sign two beats before last
        s1 = DEF_P_W'(-40) + 48'h7;
        model(RND_SYM_ZERO, DEF_P_W'(-16), 48'h7, s1[DEF_P_W-1], e, x);
        exp_q.push_back(e);
        drive(RND_SYM_ZERO, DEF_A_W'(-40), 18'h1, 48'h7, 3'h6);
        drive(RND_SYM_ZERO, 25'h10, 18'h1, 48'h7, 3'h4);
        drive(RND_SYM_ZERO, 25'h8, 18'h1, 48'h7, 3'h5);
        @(negedge I_CLK);
        I_VALID = 1'h0;
        acc = 3'h0;
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge I_CLK);
        $display("test frame done");
        `CHK(exp_q.size(), 0)
        end_sim();
    end
endmodule

// *** verification/fpru_props.sv ***
/*
 * link checks between slice and fabric: latency, sum, flags, holding.
 * assumes one clock; the bench instantiates it beside the interface.
 */
module fpru_props
    import fpru_pkg::*;
#(
    parameter int P_W = DEF_P_W,
    parameter int A_W = DEF_A_W,
    parameter int B_W = DEF_B_W
) (
    // clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_RST_N,
    // request
    input  wire logic              req_valid,
    input  wire logic [A_W-1:0]    op_a,
    input  wire logic [B_W-1:0]    op_b,
    input  wire logic [P_W-1:0]    round_const,
    input  wire logic              carry_input,
    input  wire logic [CSEL_W-1:0] carry_source_select,
    input  wire logic [OPS_W-1:0]  operation_select,
    input  wire logic              mask_single_shift,
    input  wire logic [P_W-1:0]    pattern,
    input  wire logic [P_W-1:0]    mask,
    // answer
    input  wire logic              result_valid,
    input  wire logic [P_W-1:0]    result,
    input  wire logic              match_flag,
    input  wire logic              inverse_match_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // expected word, captured when a request is taken
    // ------------------------------------------------------------
    logic [P_W-1:0] prod, nxt_sum, nxt_msk, sum_ff, pat_ff, msk_ff;
    logic           cin;
    always_comb begin
        prod    = $signed(op_a) * $signed(op_b);
        cin     = (carry_source_select == CSEL_SIGN_BAR) ?
                  ~prod[P_W-1] : carry_input;
        nxt_sum = prod + P_W'(cin)
                + (operation_select[OPS_ACCUM] ? result : '0)
                + (operation_select[OPS_ADD_CONST] ? round_const : '0);
        nxt_msk = mask_single_shift ? {~round_const[P_W-2:0], 1'b0} : mask;
    end
    // not reset: only read one cycle after a taken request
    always_ff @(posedge I_CLK) begin
        sum_ff <= req_valid ? nxt_sum : sum_ff;
        pat_ff <= req_valid ? pattern : pat_ff;
        msk_ff <= req_valid ? nxt_msk : msk_ff;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence req_s;
        req_valid;
    endsequence
    sequence ans_s;
        result_valid;
    endsequence
    answer_latency_a: assert property (req_s |=> ans_s)
        else $error("answer not one cycle after request");
    answer_cause_a: assert property (ans_s |-> $past(req_valid))
        else $error("answer without request");
    sum_value_a: assert property (ans_s |-> result == sum_ff)
        else $error("sum differs");
    match_flag_a: assert property (
        ans_s |-> match_flag == &((result ~^ pat_ff) | msk_ff))
        else $error("match flag differs");
    inverse_flag_a: assert property (
        ans_s |-> inverse_match_flag == &((result ^ pat_ff) | msk_ff))
        else $error("inverse flag differs");
    result_hold_a: assert property (!req_valid |=> !result_valid
        && $stable(result) && $stable(match_flag)
        && $stable(inverse_match_flag))
        else $error("result moved without request");
    zero_pattern_a: assert property (
        req_s and mask_single_shift |-> pattern == '0)
        else $error("dynamic pattern not zero");
    const_shape_a: assert property (
        req_valid && operation_select[OPS_ADD_CONST]
        |-> ((round_const + 1'h1) & round_const) == '0)
        else $error("constant ones not contiguous");
endmodule
